/* File: hdl/cpsc_pkg.sv */
package cpsc_pkg;
  localparam logic [3:0] CPSC_CMD_ADDR = 4'h0;
  localparam int CPSC_HALT_POS = 0;
  localparam int CPSC_ACT_POS = 1;
  localparam int CPSC_TXREQ_POS = 2;
  localparam int CPSC_RCMD_LSB = 3;
  localparam int CPSC_RCMD_MSB = 5;
  localparam int CPSC_PAGE_LSB = 6;
  localparam int CPSC_PAGE_MSB = 7;
  localparam logic [2:0] CPSC_RCMD_NONE = 3'h0;
  localparam logic [2:0] CPSC_RCMD_READ = 3'h1;
  localparam logic [2:0] CPSC_RCMD_WRITE = 3'h2;
  localparam logic [2:0] CPSC_RCMD_SEND = 3'h3;
  localparam logic [2:0] CPSC_RCMD_ABORT = 3'h4;
  localparam logic [1:0] CPSC_PAGE_RESET = 2'h0;
  localparam logic [7:0] CPSC_CMD_RESET = 8'h21;
  localparam logic [7:0] CPSC_RST_FLAG_MASK = 8'h80;
  typedef enum logic [2:0] {
    CPSC_RUN = 3'b001,
    CPSC_DRAIN = 3'b010,
    CPSC_STOPPED = 3'b100
  } cpsc_state_type;
  typedef enum logic [2:0] {
    CPSC_DMA_IDLE = 3'b001,
    CPSC_DMA_RD = 3'b010,
    CPSC_DMA_WR = 3'b100
  } cpsc_dma_type;
endpackage

/* File: hdl/cpsc_sync.sv */
module cpsc_sync import cpsc_pkg::*; #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_reg;
  // First stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stage_reg <= '0;
      sync_out <= '0;
    end else begin
      stage_reg <= async_in;
      sync_out <= stage_reg;
    end
  end
endmodule // cpsc_sync

/* File: hdl/cpsc_command.sv */
// How it works
// - Stop bit takes controller offline, set at reset
// - Active frames finish before reset state
// - Reset done only when reset flag reads set
// - Start bit activates controller, clear at reset
// - Stop while running keeps both bits set
// - Transmit request starts packet, self-clears
// - Writing zero to transmit request does nothing
// - Remote command field decode, top bit aborts
// - Reissue without count reload completes at once
// - Page, abort, stop writes always accepted
// - Abort stops DMA, address left in place
// - Aborted DMA holds port request until ack
// - Page bits choose register page, 11 reserved
// - Command register at address zero every page
// - Reset flag set entering reset, cleared by start
module cpsc_command import cpsc_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] register_address_pins,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic rx_busy,
  input wire logic tx_busy,
  input wire logic tx_done,
  input wire logic remote_count_zero,
  input wire logic remote_count_loaded,
  input wire logic read_ack,
  input wire logic write_ack,
  input wire logic [7:0] other_rdata,
  output logic [1:0] page_select,
  output logic [2:0] remote_cmd,
  output logic remote_start,
  output logic remote_abort,
  output logic remote_done,
  output logic transmit_request,
  output logic halt_request_bit,
  output logic activate_bit,
  output logic controller_online,
  output logic reset_status,
  output logic port_request,
  output logic cmd_selected
);
  logic [3:0] addr_s;
  logic cs_n_s, rd_n_s, wr_n_s;
  logic [7:0] din_s;
  logic [2:0] ctl_s;
  logic rx_busy_s, tx_busy_s, read_ack_s, write_ack_s;
  logic [3:0] misc_s;

  cpsc_sync #(.WIDTH(19)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in({register_address_pins, cs_n, rd_n, wr_n, data_in,
      rx_busy, tx_busy, read_ack, write_ack}),
    .sync_out({addr_s, cs_n_s, rd_n_s, wr_n_s, din_s,
      rx_busy_s, tx_busy_s, read_ack_s, write_ack_s})
  );
  assign ctl_s = {cs_n_s, rd_n_s, wr_n_s};
  assign misc_s = {rx_busy_s, tx_busy_s, read_ack_s, write_ack_s};

  logic wr_prev_reg;
  logic halt_reg, act_reg, txreq_reg, rst_flag_reg, prq_reg;
  logic [2:0] rcmd_reg;
  logic [1:0] page_reg;
  logic start_pulse_reg, abort_pulse_reg, done_pulse_reg;
  logic [7:0] dout_reg;
  logic oe_reg, sel_reg;
  cpsc_state_type state_reg, state_next;
  cpsc_dma_type dma_reg, dma_next;

  wire cmd_hit = !cs_n_s && (addr_s == CPSC_CMD_ADDR);
  wire wr_level = cmd_hit && !wr_n_s;
  wire wr_strobe = wr_level && !wr_prev_reg;
  wire rd_level = !cs_n_s && !rd_n_s;
  wire [2:0] w_rcmd = din_s[CPSC_RCMD_MSB:CPSC_RCMD_LSB];
  wire w_halt = din_s[CPSC_HALT_POS];
  wire w_act = din_s[CPSC_ACT_POS];
  wire w_txreq = din_s[CPSC_TXREQ_POS];
  wire w_abort = w_rcmd[2];
  wire w_read = (w_rcmd == CPSC_RCMD_READ);
  wire w_write = (w_rcmd == CPSC_RCMD_WRITE);
  wire w_send = (w_rcmd == CPSC_RCMD_SEND);
  wire frame_busy = rx_busy_s || tx_busy_s;
  // Read over write or write over read is the host's fault; ignore it
  wire dma_clash = (dma_reg == CPSC_DMA_RD && w_write) ||
    (dma_reg == CPSC_DMA_WR && w_read);
  wire new_cmd = wr_strobe && (w_read || w_write || w_send) && !dma_clash;
  // Reissue with an exhausted count has nothing to move
  wire instant_done = new_cmd && (!remote_count_loaded ||
    remote_count_zero);
  wire dma_busy = (dma_reg != CPSC_DMA_IDLE);
  wire ack_in = read_ack_s || write_ack_s;
  wire count_end = dma_busy && remote_count_zero;
  wire go_offline = wr_strobe && w_halt;
  wire go_online = wr_strobe && !w_halt && w_act;
  wire online = (state_reg == CPSC_RUN);
  wire [7:0] cmd_word = {page_reg, rcmd_reg, txreq_reg, act_reg, halt_reg};

  // Stop waits for frames in flight
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      CPSC_RUN: begin
        if (go_offline) begin
          state_next = frame_busy ? CPSC_DRAIN : CPSC_STOPPED;
        end
      end
      CPSC_DRAIN: begin
        if (go_online) begin
          state_next = CPSC_RUN;
        end else if (!frame_busy) begin
          state_next = CPSC_STOPPED;
        end
      end
      CPSC_STOPPED: begin
        if (go_online) begin
          state_next = CPSC_RUN;
        end
      end
    endcase
  end

  always_comb begin
    dma_next = dma_reg;
    unique case (dma_reg)
      CPSC_DMA_IDLE: begin
        if (new_cmd && !instant_done && !w_abort) begin
          dma_next = w_write ? CPSC_DMA_WR : CPSC_DMA_RD;
        end
      end
      CPSC_DMA_RD, CPSC_DMA_WR: begin
        if ((wr_strobe && w_abort) || count_end) begin
          dma_next = CPSC_DMA_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= CPSC_STOPPED;
      dma_reg <= CPSC_DMA_IDLE;
      // Synced pins read low until flushed; block a false strobe
      wr_prev_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      dma_reg <= dma_next;
      wr_prev_reg <= wr_level;
    end
  end

  // Command bits; page, abort and stop always land
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      {page_reg, rcmd_reg, txreq_reg, act_reg, halt_reg} <= CPSC_CMD_RESET;
    end else begin
      if (wr_strobe) begin
        page_reg <= din_s[CPSC_PAGE_MSB:CPSC_PAGE_LSB];
        if (w_abort || !dma_clash) begin
          rcmd_reg <= w_rcmd;
        end
        halt_reg <= w_halt;
        // Start stays set beside stop after running
        act_reg <= w_halt ? (act_reg | w_act) : w_act;
      end
      if (wr_strobe && w_txreq && online && !w_halt) begin
        txreq_reg <= 1'b1;
      end else if (tx_done) begin
        txreq_reg <= 1'b0;
      end
    end
  end

  // Reset flag: entering reset wins over start
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rst_flag_reg <= 1'b1;
    end else if (state_next == CPSC_STOPPED && state_reg != CPSC_STOPPED) begin
      rst_flag_reg <= 1'b1;
    end else if (go_online) begin
      rst_flag_reg <= 1'b0;
    end
  end

  // Port request drops on count end, or on an acknowledge after abort
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prq_reg <= 1'b0;
    end else if (dma_next != CPSC_DMA_IDLE && !dma_busy) begin
      prq_reg <= 1'b1;
    end else if (ack_in && (!dma_busy || count_end)) begin
      prq_reg <= 1'b0;
    end else if (count_end) begin
      prq_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      start_pulse_reg <= 1'b0;
      abort_pulse_reg <= 1'b0;
      done_pulse_reg <= 1'b0;
    end else begin
      start_pulse_reg <= new_cmd && !instant_done && !dma_busy;
      abort_pulse_reg <= wr_strobe && w_abort && dma_busy;
      done_pulse_reg <= instant_done || count_end;
    end
  end

  // Page 0..3 readback; register zero is always the command word
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dout_reg <= 8'h00;
      oe_reg <= 1'b0;
      sel_reg <= 1'b0;
    end else begin
      dout_reg <= (addr_s == CPSC_CMD_ADDR) ? cmd_word : other_rdata;
      oe_reg <= rd_level;
      sel_reg <= cmd_hit;
    end
  end

  assign data_out = dout_reg;
  assign data_oe = oe_reg;
  assign cmd_selected = sel_reg;
  assign page_select = page_reg;
  assign remote_cmd = rcmd_reg;
  assign remote_start = start_pulse_reg;
  assign remote_abort = abort_pulse_reg;
  assign remote_done = done_pulse_reg;
  assign transmit_request = txreq_reg;
  assign halt_request_bit = halt_reg;
  assign activate_bit = act_reg;
  assign reset_status = rst_flag_reg;
  assign port_request = prq_reg;
  // Registered from state_next, in step with state_reg
  logic online_reg;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      online_reg <= 1'b0;
    end else begin
      online_reg <= (state_next == CPSC_RUN);
    end
  end
  assign controller_online = online_reg;
endmodule // cpsc_command

/* File: bench/cpsc_host.sv */
module cpsc_host (
  input wire logic clk_sys,
  input wire logic [7:0] data_out,
  output logic [3:0] addr,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] data,
  output logic got
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {addr, data, cs_n, rd_n, wr_n, got} = {12'h000, 4'he};
  // Strobe held far past the two-flop sync so one access lands once
  task automatic access(input logic [3:0] a, input logic [7:0] d,
      input logic w);
    @(negedge clk_sys);
    {addr, data, cs_n, rd_n, wr_n} = {a, d, 1'b0, w, !w};
    repeat (6) @(negedge clk_sys);
    got = !w;
    @(negedge clk_sys);
    {got, cs_n, rd_n, wr_n} = 4'h7;
    // Released bus shows the inverse, never a stale copy
    data = ~data;
    repeat (3) @(negedge clk_sys);
  endtask
endmodule // cpsc_host

/* File: bench/cpsc_command_assertions.sv */
module cpsc_command_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wr_n,
  input wire logic tx_done,
  input wire logic [1:0] page_select,
  input wire logic [2:0] remote_cmd,
  input wire logic remote_start,
  input wire logic remote_abort,
  input wire logic transmit_request,
  input wire logic halt_request_bit,
  input wire logic activate_bit,
  input wire logic controller_online,
  input wire logic reset_status
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  reset_word_a: assert property ($fell(rst) |->
    halt_request_bit && !activate_bit && reset_status)
    else $error("Command bits wrong after reset");
  start_pulse_a: assert property (remote_start |=> !remote_start)
    else $error("Remote start pulse too long");
  tx_gate_a: assert property ($rose(transmit_request) |->
    activate_bit && !halt_request_bit)
    else $error("Transmit request set while offline");
  tx_clear_a: assert property (transmit_request && tx_done |->
    ##[1:3] !transmit_request)
    else $error("Transmit request not cleared");
  online_start_a: assert property (controller_online |->
    activate_bit)
    else $error("Online without start bit");
  abort_cmd_a: assert property (remote_abort |-> remote_cmd[2])
    else $error("Abort pulse without abort command");
  flag_clear_a: assert property ($fell(reset_status) |->
    activate_bit)
    else $error("Reset flag cleared without start");
  page_write_a: assert property (!$stable(page_select) |->
    !$past(wr_n, 2) || !$past(wr_n, 3) || !$past(wr_n, 4))
    else $error("Page changed without a write");
endmodule // cpsc_command_chk
bind cpsc_command cpsc_command_chk chk_u (.clk_sys, .rst, .wr_n, .tx_done,
  .page_select, .remote_cmd, .remote_start, .remote_abort,
  .transmit_request, .halt_request_bit, .activate_bit,
  .controller_online, .reset_status);

/* File: bench/test_command_page_select_control.sv */
module test_command_page_select_control;
  import cpsc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, rst = 1, rx_busy = 0, tx_busy = 0, tx_done = 0;
  logic read_ack = 0, cs_n, rd_n, wr_n, got, reset_status;
  logic [3:0] register_address_pins;
  logic [7:0] data_in, data_out, other_rdata = 8'h00;
  logic [7:0] exp_q[$];
  int n_errors = 0, samples_checked = 0, i, seed;
  initial forever #50 clk_sys = ~clk_sys;
  cpsc_command dut_u (.clk_sys, .rst, .register_address_pins, .cs_n,
    .rd_n, .wr_n, .data_in, .data_out, .data_oe(), .rx_busy, .tx_busy,
    .tx_done, .remote_count_zero(1'b0), .remote_count_loaded(1'b1),
    .read_ack, .write_ack(1'b0), .other_rdata, .page_select(),
    .remote_cmd(), .remote_start(), .remote_abort(), .remote_done(),
    .transmit_request(), .halt_request_bit(), .activate_bit(),
    .controller_online(), .reset_status, .port_request(),
    .cmd_selected());
  cpsc_host host_u (.clk_sys, .data_out, .addr(register_address_pins),
    .cs_n, .rd_n, .wr_n, .data(data_in), .got);
  task automatic final_report;
    if (n_errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  always @(posedge clk_sys) if (got) chk(data_out, exp_q.pop_front());
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host_u.access(a, 8'h00, 1'b0);
  endtask
  task automatic wr(input logic [7:0] d);
    host_u.access(CPSC_CMD_ADDR, d, 1'b1);
  endtask
  // Bounded wait: a flag that never arrives ends the run
  task automatic await_flag(input logic v);
    for (i = 0; i < 50 && reset_status !== v; i++) @(negedge clk_sys);
    chk({7'h00, reset_status}, {7'h00, v});
    if (i == 50) final_report();
  endtask
  initial begin
    seed = $urandom(32'h6f0209f3);
    repeat (4) @(negedge clk_sys);
    rst = 0;
    rd(4'h0, CPSC_CMD_RESET);
    wr(8'h22);
    await_flag(1'b0);
    wr(8'h26);
    tx_busy = 1;
    wr(8'h22);
    rd(4'h0, 8'h26);
    tx_done = 1;
    @(negedge clk_sys);
    {tx_done, tx_busy, rx_busy} = 3'h1;
    rd(4'h0, 8'h22);
    wr(8'h23);
    rd(4'h0, 8'h23);
    chk({7'h00, reset_status}, 8'h00);
    rx_busy = 0;
    await_flag(1'b1);
    wr(8'h0a);
    // Transmit joins the running read with its command kept
    wr(8'h0e);
    tx_busy = 1;
    wr(8'h12);
    rd(4'h0, 8'h0e);
    tx_done = 1;
    @(negedge clk_sys);
    {tx_done, tx_busy} = 2'h0;
    wr(8'h22);
    read_ack = 1;
    rd(4'h0, 8'h22);
    read_ack = 0;
    for (int p = 0; p < 4; p++) begin
      wr({p[1:0], 6'h22});
      rd(4'h0, {p[1:0], 6'h22});
      other_rdata = 8'($urandom);
      rd(4'($urandom_range(15, 1)), other_rdata);
    end
    final_report();
  end
endmodule // test_command_page_select_control
